/* File: logic/acfc_pkg.sv */
// Constants and types for the converter clock and format control block.
// Assumes one 200 MHz core clock; all pins arrive synchronous to it.
package acfc_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 14;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 16;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_A = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_B = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h10;

    localparam int CTRL_TWOS_BIT  = 0;
    localparam int CTRL_DCS_BIT   = 1;
    localparam int STAT_LOCK_BIT  = 0;
    localparam int STAT_TWOS_BIT  = 1;
    localparam int STAT_DCS_BIT   = 2;
    localparam int STAT_SPI_BIT   = 3;

    localparam logic CTRL_TWOS_RST = 1'h0;
    localparam logic CTRL_DCS_RST  = 1'h0;

    // ****************************************************************
    // Strap levels, coded by the pin's analog level
    // ****************************************************************
    typedef enum logic [1:0] {
        STRAP_AGND       = 2'b00,
        STRAP_THIRD      = 2'b01,
        STRAP_TWO_THIRDS = 2'b10,
        STRAP_VA         = 2'b11
    } acfc_strap_type;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LOCK_TIME_NS  = 4000;
    localparam int LOCK_CYC      =
        (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_W        = $clog2(LOCK_CYC + 1);

endpackage

/* File: logic/acfc_lock_if.sv */
// Carrier between the control core and its timing loop lock tracker.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface acfc_lock_if;
    logic relock;
    logic locked;
    logic busy;

    modport tracker (input relock, output locked, output busy);
    modport user    (output relock, input locked, input busy);
endinterface

/* File: logic/acfc_lock_track.sv */
// Lock tracker for the internal timing loop.
// Assumes the relock pin is synchronous and driven low in normal use.
`timescale 1ns/1ps
module acfc_lock_track
    import acfc_pkg::*;
(
    input  wire logic   core_clk_in,
    input  wire logic   resetn_in,
    acfc_lock_if.tracker lk
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              relock_prev;
        logic              locked;
        logic [LOCK_W-1:0] cnt;
    } acfc_lock_state_type;

    acfc_lock_state_type st_r;
    acfc_lock_state_type st_nxt;

    always_comb begin
        st_nxt             = st_r;
        st_nxt.relock_prev = lk.relock;
        if (lk.relock && !st_r.relock_prev) begin
            st_nxt.locked = 1'b0;
            st_nxt.cnt    = '0;
        end else if (!st_r.locked) begin
            if (st_r.cnt == LOCK_W'(LOCK_CYC - 1)) begin
                st_nxt.locked = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lk.locked = st_r.locked;
    assign lk.busy   = !st_r.locked;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_lock_drop: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        $rose(lk.relock) |=> !lk.locked)
        else $error("lock kept after relock");

    a_lock_regain: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        $rose(lk.locked) |-> $past(st_r.cnt) == LOCK_W'(LOCK_CYC - 1))
        else $error("lock regained at wrong time");

endmodule

/* File: logic/acfc_core.sv */
// Clock, relock and output format control of a dual pipelined converter.
// Assumes synchronous pins, an APB master, and one 200 MHz core clock.
`timescale 1ns/1ps
module acfc_core
    import acfc_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              conv_clk_in,
    input  wire logic [DATA_W-1:0] ain_a_in,
    input  wire logic [DATA_W-1:0] ain_b_in,
    input  wire logic              dll_relock_in,
    input  wire logic [1:0]        format_stabilizer_strap_in,
    input  wire logic              spi_en_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic      [DATA_W-1:0] dout_a_out,
    output logic      [DATA_W-1:0] dout_b_out,
    output logic                   dout_valid_out,
    output logic                   twos_comp_out,
    output logic                   dcs_en_out,
    output logic                   dll_locked_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              conv_prev;
        logic [DATA_W-1:0] word_a;
        logic [DATA_W-1:0] word_b;
        logic              valid;
        logic              twos;
        logic              dcs;
        logic              ctrl_twos;
        logic              ctrl_dcs;
        logic [31:0]       rdata;
        logic [CNT_W-1:0]  count;
    } acfc_core_state_type;

    acfc_core_state_type st_r;
    acfc_core_state_type st_nxt;

    acfc_lock_if lk ();

    acfc_lock_track u_lock (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .lk          (lk)
    );

    assign lk.relock = dll_relock_in;

    // ****************************************************************
    // Mode select and register decode
    // ****************************************************************
    acfc_strap_type     strap;
    logic               strap_twos;
    logic               strap_dcs;
    logic               mode_twos;
    logic               mode_dcs;
    logic               conv_rise;
    logic               setup;
    logic               access;
    logic               hit;
    logic [DATA_W-1:0]  msb_mask;

    assign strap     = acfc_strap_type'(format_stabilizer_strap_in);
    assign conv_rise = conv_clk_in && !st_r.conv_prev;
    assign setup     = psel_in && !penable_in;
    assign access    = psel_in && penable_in;
    assign hit       = (paddr_in == OFF_CTRL) || (paddr_in == OFF_STATUS)
                    || (paddr_in == OFF_SAMPLE_A)
                    || (paddr_in == OFF_SAMPLE_B)
                    || (paddr_in == OFF_COUNT);

    always_comb begin
        strap_twos = 1'b0;
        strap_dcs  = 1'b0;
        unique case (strap)
            STRAP_VA: begin
                strap_twos = 1'b1;
                strap_dcs  = 1'b0;
            end
            STRAP_AGND: begin
                strap_twos = 1'b0;
                strap_dcs  = 1'b0;
            end
            STRAP_TWO_THIRDS: begin
                strap_twos = 1'b1;
                strap_dcs  = 1'b1;
            end
            STRAP_THIRD: begin
                strap_twos = 1'b0;
                strap_dcs  = 1'b1;
            end
        endcase
    end

    assign mode_twos = spi_en_in ? st_r.ctrl_twos : strap_twos;
    assign mode_dcs  = spi_en_in ? st_r.ctrl_dcs  : strap_dcs;

    // Top bit flip for two's complement
    assign msb_mask = {mode_twos, {(DATA_W-1){1'b0}}};

    always_comb begin
        st_nxt           = st_r;
        st_nxt.conv_prev = conv_clk_in;
        st_nxt.twos      = mode_twos;
        st_nxt.dcs       = mode_dcs;
        st_nxt.valid     = 1'b0;
        if (conv_rise) begin
            st_nxt.word_a = ain_a_in ^ msb_mask;
            st_nxt.word_b = ain_b_in ^ msb_mask;
            st_nxt.valid  = 1'b1;
            st_nxt.count  = st_r.count + 1'b1;
        end
        // Read data latched in setup, stable through access
        if (setup && !pwrite_in) begin
            st_nxt.rdata = '0;
            unique case (paddr_in)
                OFF_CTRL: begin
                    st_nxt.rdata[CTRL_TWOS_BIT] = st_r.ctrl_twos;
                    st_nxt.rdata[CTRL_DCS_BIT]  = st_r.ctrl_dcs;
                end
                OFF_STATUS: begin
                    st_nxt.rdata[STAT_LOCK_BIT] = !lk.busy;
                    st_nxt.rdata[STAT_TWOS_BIT] = st_r.twos;
                    st_nxt.rdata[STAT_DCS_BIT]  = st_r.dcs;
                    st_nxt.rdata[STAT_SPI_BIT]  = spi_en_in;
                end
                OFF_SAMPLE_A: st_nxt.rdata[DATA_W-1:0] = st_r.word_a;
                OFF_SAMPLE_B: st_nxt.rdata[DATA_W-1:0] = st_r.word_b;
                OFF_COUNT:    st_nxt.rdata[CNT_W-1:0]  = st_r.count;
                default:      st_nxt.rdata = '0;
            endcase
        end
        if (access && pwrite_in && (paddr_in == OFF_CTRL)) begin
            st_nxt.ctrl_twos = pwdata_in[CTRL_TWOS_BIT];
            st_nxt.ctrl_dcs  = pwdata_in[CTRL_DCS_BIT];
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r           <= '0;
            st_r.ctrl_twos <= CTRL_TWOS_RST;
            st_r.ctrl_dcs  <= CTRL_DCS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata_out     = st_r.rdata;
    assign pready_out     = 1'b1;
    assign pslverr_out    = access && !hit;
    assign dout_a_out     = st_r.word_a;
    assign dout_b_out     = st_r.word_b;
    assign dout_valid_out = st_r.valid;
    assign twos_comp_out  = st_r.twos;
    assign dcs_en_out     = st_r.dcs;
    assign dll_locked_out = lk.locked;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sample_strobe: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        resetn_in && $rose(conv_clk_in)
        |=> dout_valid_out ##1 !dout_valid_out)
        else $error("sample not captured on conversion edge");

    a_sample_word: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        dout_valid_out |-> dout_b_out ==
            ($past(ain_b_in) ^ {twos_comp_out, {(DATA_W-1){1'b0}}}))
        else $error("output word format wrong");

    a_strap_supply: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!spi_en_in && format_stabilizer_strap_in == STRAP_VA)
        |=> twos_comp_out && !dcs_en_out)
        else $error("supply strap decoded wrong");

    a_strap_ground: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!spi_en_in && format_stabilizer_strap_in == STRAP_AGND)
        |=> !twos_comp_out && !dcs_en_out)
        else $error("ground strap decoded wrong");

    a_strap_two_thirds: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!spi_en_in && format_stabilizer_strap_in == STRAP_TWO_THIRDS)
        |=> twos_comp_out && dcs_en_out)
        else $error("two thirds strap decoded wrong");

    a_strap_third: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!spi_en_in && format_stabilizer_strap_in == STRAP_THIRD)
        |=> !twos_comp_out && dcs_en_out)
        else $error("one third strap decoded wrong");

    a_spi_override: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        spi_en_in |=> twos_comp_out == $past(st_r.ctrl_twos)
                   && dcs_en_out == $past(st_r.ctrl_dcs))
        else $error("strap not ignored under serial control");

    a_relock_unlock: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        $rose(dll_relock_in) |=> !dll_locked_out [*8])
        else $error("locked too soon after relock");

endmodule

/* File: sim/acfc_ctrl_model.sv */
// System controller model: conversion clock and relock pulse.
// Assumes the core clock runs at 200 MHz; the bench asks for relocks.
`timescale 1ns/1ps
module acfc_ctrl_model
#(
    parameter int RELOCK_CYC = 200,
    parameter int HALF_CYC   = 4
)
(
    input  wire logic core_clk_in,
    input  wire logic relock_go_in,
    output logic      conv_clk_out,
    output logic      dll_relock_out
);
    int half_cnt_r  = 0;
    int pulse_cnt_r = 0;

    initial conv_clk_out = 1'b0;
    initial dll_relock_out = 1'b0;

    always @(posedge core_clk_in) begin
        if (half_cnt_r == HALF_CYC - 1) begin
            half_cnt_r <= 0;
            conv_clk_out <= ~conv_clk_out;
        end else begin
            half_cnt_r <= half_cnt_r + 1;
        end
    end

    // low except one 1 us pulse
    always @(posedge core_clk_in) begin
        if (pulse_cnt_r != 0) begin
            pulse_cnt_r <= pulse_cnt_r - 1;
            if (pulse_cnt_r == 1) begin
                dll_relock_out <= 1'b0;
            end
        end else if (relock_go_in) begin
            pulse_cnt_r <= RELOCK_CYC;
            dll_relock_out <= 1'b1;
        end
    end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the converter clock and format control block.
// Assumes the controller model drives conversion clock and relock pins.
`timescale 1ns/1ps
module tb;
    import acfc_pkg::*;
    logic clk, resetn, conv_clk, relock, relock_go, spi_en;
    logic psel, penable, pwrite, pready, pslverr, dvalid, twos, dcs, locked;
    logic [1:0] strap;
    logic [DATA_W-1:0] ain_a, ain_b, dout_a, dout_b;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    acfc_ctrl_model acfc_ctrl_model_i (.core_clk_in(clk),
        .relock_go_in(relock_go), .conv_clk_out(conv_clk),
        .dll_relock_out(relock));
    acfc_core acfc_core_i (.core_clk_in(clk), .resetn_in(resetn),
        .conv_clk_in(conv_clk), .ain_a_in(ain_a), .ain_b_in(ain_b),
        .dll_relock_in(relock), .format_stabilizer_strap_in(strap),
        .spi_en_in(spi_en), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .dout_a_out(dout_a), .dout_b_out(dout_b), .dout_valid_out(dvalid),
        .twos_comp_out(twos), .dcs_en_out(dcs), .dll_locked_out(locked));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic [ADDR_W-1:0] a, input logic wr,
                       input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        @(posedge clk);
        while (dvalid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check(n < 50, 1'b1);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_start_lock();
        check(locked, 1'b0);
        tick(790);
        check(locked, 1'b0);
        tick(20);
        check(locked, 1'b1);
    endtask

    task automatic t_modes();
        logic [DATA_W-1:0] a_tab [4] = '{14'h3FFF, 14'h2000, 14'h0001, 14'h2A5C};
        logic [DATA_W-1:0] b_tab [4] = '{14'h0000, 14'h1FFF, 14'h3FFE, 14'h15A3};
        logic tc;
        logic [31:0] cnt;
        for (int i = 0; i < 4; i++) begin
            strap <= 2'(i);
            ain_a <= a_tab[i];
            ain_b <= b_tab[i];
            tick(3);
            tc = (i >= 2);
            check(twos, tc);
            check(dcs, (i == 1 || i == 2));
            wait_valid();
            wait_valid();
            check(dout_a, a_tab[i] ^ {tc, 13'h0000});
            check(dout_b, b_tab[i] ^ {tc, 13'h0000});
            apb(OFF_SAMPLE_A, 1'b0, 32'h0);
            check(rd, {18'h0, a_tab[i] ^ {tc, 13'h0000}});
            apb(OFF_SAMPLE_B, 1'b0, 32'h0);
            check(rd, {18'h0, b_tab[i] ^ {tc, 13'h0000}});
        end
        wait_valid();
        apb(OFF_COUNT, 1'b0, 32'h0);
        cnt = rd;
        wait_valid();
        apb(OFF_COUNT, 1'b0, 32'h0);
        check(rd, {16'h0, cnt[15:0] + 16'h0001});
    endtask

    task automatic t_serial();
        logic [1:0] c;
        spi_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            strap <= {~c[0], c[1] ^ c[0]};
            apb(OFF_CTRL, 1'b1, {30'h0, c});
            tick(2);
            check(twos, c[0]);
            check(dcs, c[1]);
            apb(OFF_STATUS, 1'b0, 32'h0);
            check(rd & 32'hF, {28'h0, 1'b1, c[1], c[0], 1'b1});
            apb(OFF_CTRL, 1'b0, 32'h0);
            check(rd, {30'h0, c});
        end
        apb(8'h40, 1'b0, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        spi_en <= 1'b0;
        tick(2);
    endtask

    task automatic t_relock();
        int n;
        n = 0;
        relock_go <= 1'b1;
        @(posedge clk);
        relock_go <= 1'b0;
        while (relock !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        tick(5);
        check(locked, 1'b0);
        n = 5;
        while (locked !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check(n >= 790 && n <= 805, 1'b1);
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    initial begin
        resetn = 1'b0;
        relock_go = 1'b0;
        spi_en = 1'b0;
        strap = STRAP_AGND;
        ain_a = '0;
        ain_b = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        tick(5);
        resetn <= 1'b1;
        @(posedge clk);
        t_start_lock();
        t_modes();
        t_serial();
        t_relock();
        results();
    end
endmodule
